// File: core/wdt_defines.svh
// Constants for the configuration-word watchdog: offsets, fields, resets.
// Assumes inclusion from the package and the design files by bare name.
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ********************************************************************
// Register offsets (byte addresses on the plain register port)
// ********************************************************************
`define WDT_ADDR_W        8
`define WDT_OFF_CFG       8'h00
`define WDT_OFF_CTRL      8'h04
`define WDT_OFF_SERVICE   8'h08
`define WDT_OFF_STATUS    8'h0C
`define WDT_OFF_MASK      8'h10
`define WDT_OFF_COUNT     8'h14

// ********************************************************************
// Configuration word field positions
// ********************************************************************
`define WDT_WINSZ_HI      25
`define WDT_WINSZ_LO      24
`define WDT_EN_BIT        23
`define WDT_WDT_WINDOW_DISABLE_CFG_BIT    22
`define WDT_PS_HI         20
`define WDT_PS_LO         16
`define WDT_PS_MAX        5'h14

// ********************************************************************
// Status, control bits and reset values
// ********************************************************************
`define WDT_ST_TIMEOUT    0
`define WDT_ST_EARLY      1
`define WDT_CTRL_ON       0
`define WDT_CTRL_RUN      1
`define WDT_STATUS_RST    2'h0
`define WDT_MASK_RST      2'h0
`define WDT_CFG_RST       32'h0000_0000
`define WDT_SETTLE_LAST   2'h3

// ********************************************************************
// Timing
// ********************************************************************
`define WDT_BASE_CYCLES   100
`define WDT_TICK_W        21

`endif

// File: core/wdt_pkg.sv
// Types shared by the watchdog configuration decoder and its top module.
// Assumes wdt_defines.svh is on the include path.
package wdt_pkg;
  `include "wdt_defines.svh"

  // ******************************************************************
  // Enumerations
  // ******************************************************************
  typedef enum logic {PH_SAMPLE, PH_ACTIVE} phase_e;          // Fuse capture phase
  typedef enum logic [1:0] {WIN_75, WIN_50, WIN_37P5, WIN_25} win_size_e;

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic [`WDT_ADDR_W-1:0] addr;      // Byte address
    logic [31:0]            wdata;     // Write data
    logic                   wr;        // Write strobe
    logic                   rd;        // Read strobe
  } bus_req_s;

  typedef struct packed {
    logic                   enable;    // Run from reset, locked on
    logic                   windowed;  // Window mode selected
    win_size_e              win;       // Final window size
    logic [4:0]             ps;        // Effective postscale code
    logic [`WDT_TICK_W-1:0] period;    // Ticks per timeout
    logic [`WDT_TICK_W-1:0] open_at;   // First tick inside the window
  } wdt_cfg_s;

  typedef struct packed {
    logic [31:0]            sync1;     // Fuse synchroniser stages
    logic [31:0]            sync2;
    logic [31:0]            sync3;
    logic [1:0]             settle;    // Pipeline fill count
    phase_e                 phase;
    logic [31:0]            cfg_word;  // Captured configuration word
    logic                   ctrl_on;   // Software run request
    logic                   running;
    logic [15:0]            pre_cnt;   // Base clock divider
    logic [`WDT_TICK_W-1:0] tick_cnt;  // Postscaled tick count
    logic                   expire;    // Timeout event pulse
    logic [1:0]             status;    // Sticky events
    logic [1:0]             mask;      // Interrupt mask
    logic                   irq;
    logic [31:0]            rdata;
  } wdt_state_s;
endpackage

// File: core/wdt_cfg_decode.sv
// Pure decoder from the configuration word to watchdog settings.
// Assumes a stable word; output is combinational from its input.
`timescale 1ns/1ps
`include "wdt_defines.svh"

module wdt_cfg_decode (
  // Raw configuration word
  input  wire logic [31:0]      word,
  // Decoded settings
  output wdt_pkg::wdt_cfg_s     cfg
);
  import wdt_pkg::*;

  logic [4:0]             ps_raw;   // Code as programmed
  logic [`WDT_TICK_W-1:0] p;        // Period shorthand

  // ******************************************************************
  // Field decode
  // ******************************************************************
  always_comb begin
    cfg          = '0;
    cfg.enable   = word[`WDT_EN_BIT];
    cfg.windowed = ~word[`WDT_WDT_WINDOW_DISABLE_CFG_BIT];
    cfg.win      = win_size_e'(word[`WDT_WINSZ_HI:`WDT_WINSZ_LO]);
    ps_raw       = word[`WDT_PS_HI:`WDT_PS_LO];
    // Undefined codes behave as the largest ratio
    cfg.ps       = (ps_raw > `WDT_PS_MAX) ? `WDT_PS_MAX : ps_raw;
    p            = `WDT_TICK_W'(1) << cfg.ps;
    cfg.period   = p;
    // Window opens once the final fraction is reached
    unique case (cfg.win)
      WIN_25:   cfg.open_at = p - (p >> 2);
      WIN_37P5: cfg.open_at = p - (p >> 2) - (p >> 3);
      WIN_50:   cfg.open_at = p - (p >> 1);
      WIN_75:   cfg.open_at = p >> 2;
    endcase
  end
endmodule

// File: core/watchdog_config_word_decode.sv
// Watchdog timer steered by a nonvolatile configuration word.
// Assumes the fuse word is static after reset and comes from another
// domain; software uses the plain register port on mclk.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "wdt_defines.svh"

module watchdog_config_word_decode #(
  parameter int unsigned BASE_CYCLES = `WDT_BASE_CYCLES  // Clocks per base tick
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Fuse array
  input  wire logic [31:0]       fuse_word,
  // Register port
  input  wdt_pkg::bus_req_s      bus,
  output logic [31:0]            rdata,
  // Watchdog results
  output logic                   timeout_evt,
  output logic                   wdt_running,
  output logic                   irq
);
  import wdt_pkg::*;

  // ******************************************************************
  // Elaboration checks
  // ******************************************************************
  // The divider is 16 bits wide; a zero base count would never tick
  if (BASE_CYCLES < 1 || BASE_CYCLES > 65536) begin : g_bad_base
    $error("BASE_CYCLES must lie in 1..65536");
  end

  localparam logic [15:0] PRE_LAST = 16'(BASE_CYCLES - 1); // Divider wrap

  // ******************************************************************
  // Declarations
  // ******************************************************************
  wdt_state_s s_q;          // All state
  wdt_state_s s_d;          // Next state
  wdt_cfg_s   cfg;          // Decoded captured word
  logic       svc_wr;       // Software service request
  logic       ctrl_wr;      // Control write
  logic [1:0] set_ev;       // Events raised this cycle
  logic [1:0] status_clr;   // Status after software clear

  // Register map on the plain port, byte offsets:
  //   CFG     read-only copy of the captured word
  //   CTRL    bit 0 software run request, bit 1 running (read-only)
  //   SERVICE write a one to bit 0 to restart the period
  //   STATUS  bit 0 timeout, bit 1 early service, write one to clear
  //   MASK    interrupt enables, same layout as STATUS
  //   COUNT   postscaled tick count, read-only
  // Unmapped offsets read as zero and ignore writes, so a stray
  // access can never disturb the timer.

  // ******************************************************************
  // Configuration decoder
  // ******************************************************************
  wdt_cfg_decode u_decode (
    .word (s_q.cfg_word),
    .cfg  (cfg)
  );

  // Write decode shared by next-state logic and checks
  assign svc_wr  = bus.wr && (bus.addr == `WDT_OFF_SERVICE) && bus.wdata[0];
  assign ctrl_wr = bus.wr && (bus.addr == `WDT_OFF_CTRL);

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    s_d        = s_q;
    set_ev     = 2'h0;
    status_clr = s_q.status;
    // Three-stage synchroniser on the fuse word
    s_d.sync1  = fuse_word;
    s_d.sync2  = s_q.sync1;
    s_d.sync3  = s_q.sync2;
    s_d.expire = 1'b0;
    s_d.rdata  = 32'h0;

    // Fuse capture once the pipeline is full and stable
    // Waiting for two agreeing stages keeps a word that is still
    // settling at power-up from being frozen half-read
    unique case (s_q.phase)
      PH_SAMPLE: begin
        if (s_q.settle != `WDT_SETTLE_LAST) begin
          s_d.settle = s_q.settle + 2'h1;
        end else if (s_q.sync2 == s_q.sync3) begin
          s_d.cfg_word = s_q.sync3;
          s_d.phase    = PH_ACTIVE;
        end
      end
      PH_ACTIVE: begin
        // Word is frozen until the next reset
      end
    endcase

    // Register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `WDT_OFF_CTRL:   s_d.ctrl_on = bus.wdata[`WDT_CTRL_ON];
        `WDT_OFF_STATUS: status_clr  = s_q.status & ~bus.wdata[1:0];
        `WDT_OFF_MASK:   s_d.mask    = bus.wdata[1:0];
        default: begin
          // Config, service, count and holes take no stored value
        end
      endcase
    end

    // Register reads, data in the following cycle only
    if (bus.rd) begin
      unique case (bus.addr)
        `WDT_OFF_CFG:    s_d.rdata = s_q.cfg_word;
        `WDT_OFF_CTRL:   s_d.rdata = {30'h0, s_q.running, s_q.ctrl_on};
        `WDT_OFF_STATUS: s_d.rdata = {30'h0, s_q.status};
        `WDT_OFF_MASK:   s_d.rdata = {30'h0, s_q.mask};
        `WDT_OFF_COUNT:  s_d.rdata = {11'h0, s_q.tick_cnt};
        default:         s_d.rdata = 32'h0;
      endcase
    end

    // The fuse enable overrides any software off request
    s_d.running = (s_q.phase == PH_ACTIVE) && (cfg.enable || s_d.ctrl_on);

    // Counting and service
    if (!s_q.running) begin
      // Stopped: hold at zero so a start begins a full period
      s_d.pre_cnt  = 16'h0;
      s_d.tick_cnt = '0;
    end else if (svc_wr && cfg.windowed && (s_q.tick_cnt < cfg.open_at)) begin
      // Too-early service counts as a fault, same effect as timeout
      set_ev[`WDT_ST_EARLY] = 1'b1;
      s_d.expire   = 1'b1;
      s_d.pre_cnt  = 16'h0;
      s_d.tick_cnt = '0;
    end else if (svc_wr) begin
      // Legal service restarts the period
      s_d.pre_cnt  = 16'h0;
      s_d.tick_cnt = '0;
    end else if (s_q.pre_cnt == PRE_LAST) begin
      s_d.pre_cnt = 16'h0;
      if (s_q.tick_cnt == cfg.period - `WDT_TICK_W'(1)) begin
        // Base count times ratio has elapsed
        set_ev[`WDT_ST_TIMEOUT] = 1'b1;
        s_d.expire   = 1'b1;
        s_d.tick_cnt = '0;
      end else begin
        s_d.tick_cnt = s_q.tick_cnt + `WDT_TICK_W'(1);
      end
    end else begin
      s_d.pre_cnt = s_q.pre_cnt + 16'h1;
    end

    // A new event wins over a clear in the same cycle
    s_d.status = status_clr | set_ev;
    s_d.irq    = |(s_d.status & s_d.mask);
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.phase    <= PH_SAMPLE;
      s_q.cfg_word <= `WDT_CFG_RST;
      s_q.status   <= `WDT_STATUS_RST;
      s_q.mask     <= `WDT_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ******************************************************************
  // Outputs, all from flip-flops
  // ******************************************************************
  // Registered outputs keep glitches off the interrupt line and
  // off the event pulse seen by the reset logic outside
  assign rdata       = s_q.rdata;
  assign timeout_evt = s_q.expire;
  assign wdt_running = s_q.running;
  assign irq         = s_q.irq;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Shorthands for the checks
  logic       active;      // Word captured
  logic [4:0] ps_word;     // Programmed code
  assign active  = (s_q.phase == PH_ACTIVE);
  assign ps_word = s_q.cfg_word[`WDT_PS_HI:`WDT_PS_LO];
  logic       early_now;   // Early service this cycle
  logic       end_now;     // Period end this cycle
  assign early_now = s_q.running && svc_wr && cfg.windowed && (s_q.tick_cnt < cfg.open_at);
  assign end_now   = s_q.running && !svc_wr && (s_q.pre_cnt == PRE_LAST) &&
                     (s_q.tick_cnt == cfg.period - `WDT_TICK_W'(1));

  // Software tries to stop a fuse-enabled watchdog
  sequence sw_off_try;
    active && cfg.enable && ctrl_wr && !bus.wdata[`WDT_CTRL_ON];
  endsequence

  // Service before the window while running in window mode
  sequence early_service;
    s_q.running && svc_wr && cfg.windowed && (s_q.tick_cnt < cfg.open_at);
  endsequence

  // Last base tick of the last postscaled tick, no service
  sequence period_end;
    s_q.running && !svc_wr && (s_q.pre_cnt == PRE_LAST) &&
      (s_q.tick_cnt == cfg.period - `WDT_TICK_W'(1));
  endsequence

  // Quarter window opens at three quarters of the period
  chk_win_quarter: assert property (
    active && (s_q.cfg_word[25:24] == 2'b11) |->
      cfg.open_at == cfg.period - (cfg.period >> 2))
    else $error("25 percent window opens at the wrong tick");

  // Three-quarter window opens at one quarter
  chk_win_wide: assert property (
    active && (s_q.cfg_word[25:24] == 2'b00) |->
      cfg.open_at == (cfg.period >> 2))
    else $error("75 percent window opens at the wrong tick");

  // Fuse enable keeps the timer running through a stop write
  chk_locked_on: assert property (
    sw_off_try |=> s_q.running ##1 s_q.running)
    else $error("software stopped a fuse-enabled watchdog");

  // Fuse clear: stopped after capture unless software starts it
  chk_starts_off: assert property (
    $rose(active) && !s_q.cfg_word[`WDT_EN_BIT] && !s_q.ctrl_on && !ctrl_wr
      |=> !s_q.running)
    else $error("watchdog ran without fuse or software enable");

  // Software start takes effect the next cycle
  chk_sw_start: assert property (
    active && ctrl_wr && bus.wdata[`WDT_CTRL_ON] |=> s_q.running)
    else $error("software start ignored");

  // Window mode follows the inverted disable bit
  chk_window_mode: assert property (
    active |-> (cfg.windowed == !s_q.cfg_word[`WDT_WDT_WINDOW_DISABLE_CFG_BIT]))
    else $error("window mode does not follow the disable bit");

  // Defined codes give a power-of-two ratio
  chk_ratio_pow2: assert property (
    active && (ps_word <= `WDT_PS_MAX) |->
      cfg.period == (`WDT_TICK_W'(1) << ps_word))
    else $error("postscale ratio is not two to the code");

  // Undefined codes give the largest ratio
  chk_ratio_clamp: assert property (
    active && (ps_word > `WDT_PS_MAX) |-> cfg.period == 21'h10_0000)
    else $error("undefined postscale code not treated as largest");

  // Enable comes from bit 23 of the word
  chk_enable_bit: assert property (
    active |-> (cfg.enable == s_q.cfg_word[23]) &&
      (cfg.win == win_size_e'(s_q.cfg_word[25:24])))
    else $error("enable or window field read from wrong bits");

  // Early service raises the fault and the timeout event; services
  // may come back to back, so the next cycle may fault again
  chk_early_fault: assert property (
    early_service |=> s_q.expire && s_q.status[`WDT_ST_EARLY] &&
      (s_q.tick_cnt == '0) && (s_q.pre_cnt == 16'h0))
    else $error("early service in window mode not faulted");

  // Period end raises one timeout pulse and restarts
  chk_timeout: assert property (
    period_end |=> s_q.expire && s_q.status[`WDT_ST_TIMEOUT] &&
      (s_q.tick_cnt == '0))
    else $error("timeout not raised at end of period");

  // Timeout pulses only at a period end or an early service
  chk_no_spurious: assert property (
    !(early_now || end_now) |=> !s_q.expire)
    else $error("timeout pulse without cause");

  // Any service while running restarts both counters
  chk_svc_restart: assert property (
    s_q.running && svc_wr |=> (s_q.tick_cnt == '0) && (s_q.pre_cnt == 16'h0))
    else $error("service did not restart the period");

  // A stopped timer holds both counters at zero
  chk_stop_clear: assert property (
    !s_q.running |=> (s_q.tick_cnt == '0) && (s_q.pre_cnt == 16'h0))
    else $error("stopped watchdog kept counting");

  // Nothing runs before the word is captured
  chk_run_captured: assert property (
    !active |=> !s_q.running)
    else $error("watchdog ran before the word was captured");

  // Capture takes the third stage once two stages agree
  chk_capture_sync: assert property (
    !active && (s_q.settle == `WDT_SETTLE_LAST) && (s_q.sync2 == s_q.sync3) |=>
      active && (s_q.cfg_word == $past(s_q.sync3)))
    else $error("fuse word not captured from agreeing stages");

  // The captured word stays frozen until the next reset
  chk_word_frozen: assert property (
    active |=> active && $stable(s_q.cfg_word))
    else $error("captured word changed at run time");

  // Reading offset zero returns the captured word
  chk_cfg_readback: assert property (
    active && bus.rd && (bus.addr == `WDT_OFF_CFG) |=> s_q.rdata == $past(s_q.cfg_word))
    else $error("configuration readback differs from captured word");

  // A timeout flag stays set until software clears it
  chk_status_sticky: assert property (
    s_q.status[`WDT_ST_TIMEOUT] &&
      !(bus.wr && (bus.addr == `WDT_OFF_STATUS) && bus.wdata[`WDT_ST_TIMEOUT])
      |=> s_q.status[`WDT_ST_TIMEOUT])
    else $error("timeout flag lost without a clear");

  // Interrupt line is the registered or of enabled flags
  chk_irq_level: assert property (
    s_q.irq == |(s_q.status & s_q.mask))
    else $error("interrupt line does not match enabled flags");
endmodule

// File: sim/test_watchdog_config_word_decode.sv
// Self-checking bench for the configuration-word watchdog.
// Assumes the core/ files are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`include "wdt_defines.svh"

module test_watchdog_config_word_decode;
  import wdt_pkg::*;

  // ******************************************************************
  // Bench signals
  // ******************************************************************
  localparam int BASE  = 2;            // Short base count keeps periods brief
  localparam int TICKS = 8;            // Ticks per period for code 00011
  logic        mclk;                   // Main clock
  logic        rst;                    // Async reset
  logic [31:0] fuse_word;              // Fuse array value
  bus_req_s    bus;                    // Register request
  logic [31:0] rdata;                  // Read data
  logic        timeout_evt;            // Timeout pulse
  logic        wdt_running;            // Counting flag
  logic        irq;                    // Interrupt line
  int          fails;                  // Mismatches
  int          samples_checked;        // Comparisons
  logic        evt_seen;               // Pulse seen after a write
  logic [31:0] rd_val;                 // Last read value
  logic [31:0] ref_cnt;                // Expected tick count at the read
  logic [31:0] w;                      // Current fuse word
  int          n;                      // Cycles waited

  // ******************************************************************
  // Device and clock
  // ******************************************************************
  watchdog_config_word_decode #(.BASE_CYCLES(BASE)) dut_u (
    .mclk        (mclk),
    .rst         (rst),
    .fuse_word   (fuse_word),
    .bus         (bus),
    .rdata       (rdata),
    .timeout_evt (timeout_evt),
    .wdt_running (wdt_running),
    .irq         (irq)
  );

  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Single comparison point; an unknown never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One-cycle write; notes any pulse in the cycle after it
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
    #1;
    evt_seen = timeout_evt;
    @(posedge mclk);
    #1;
  endtask

  // One-cycle read; data stand only in the following cycle
  task automatic rd_reg(input logic [7:0] a);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    rd_val = rdata;
    @(posedge mclk);
    #1;
  endtask

  // Bounded wait for the next timeout pulse; n holds the cycles spent
  task automatic wait_evt(input int lim);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (timeout_evt !== 1'b1 && n < lim);
    if (timeout_evt !== 1'b1) begin
      fails++;
      $display("Error at %0t: no timeout pulse", $time);
      stop_test();
    end
  endtask

  // Reset with a new fuse word, then let the capture finish
  task automatic do_reset(input logic [31:0] fw);
    rst       <= 1'b1;
    fuse_word <= fw;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask

  // Service k cycles after a timeout restarted the count
  task automatic svc_at(input int k);
    wait_evt(100);
    repeat (k) @(posedge mclk);
    wr_reg(`WDT_OFF_SERVICE, 32'h1);
  endtask

  // Fuse word with reserved bits high and random clock fields
  function automatic logic [31:0] mk_word(input logic [1:0] wz, input logic en,
                                          input logic wd, input logic [4:0] ps);
    return {6'h3F, wz, en, wd, 1'b1, ps, 16'($urandom)};
  endfunction

  // Timeout in clocks; codes past the table act as the largest
  function automatic logic [31:0] exp_period(input logic [4:0] ps);
    return 32'(BASE) << ((ps > 5'h14) ? 5'h14 : ps);
  endfunction

  // First tick inside the final window
  function automatic int open_at(input int wz);
    case (wz)
      3: return TICKS - TICKS / 4;
      2: return TICKS - TICKS / 4 - TICKS / 8;
      1: return TICKS - TICKS / 2;
      default: return TICKS / 4;
    endcase
  endfunction

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    mclk            = 1'b0;
    rst             = 1'b1;
    fuse_word       = '0;
    bus             = '0;
    fails           = 0;
    samples_checked = 0;
    evt_seen        = 1'b0;
    ref_cnt         = 32'((8 + 600 - 5) / BASE); // Running from 5th edge after release
    void'($urandom(32'h6767CFB9));
    // Locked-on watchdog: period per code, software off ignored
    for (int ps = 0; ps < 5; ps++) begin
      w = mk_word(2'($urandom), 1'b1, 1'b1, 5'(ps));
      do_reset(w);
      check(32'(wdt_running), 32'h1);
      wr_reg(`WDT_OFF_CFG, ~w);
      rd_reg(`WDT_OFF_CFG);
      check(rd_val, w);
      rd_reg(8'h18 + 8'(4 * $urandom_range(0, 57)));
      check(rd_val, 32'h0);
      wr_reg(`WDT_OFF_CTRL, 32'h0);
      rd_reg(`WDT_OFF_CTRL);
      check(32'(rd_val[1]), 32'h1);
      wait_evt(2000);
      wait_evt(2000);
      check(32'(n), exp_period(5'(ps)));
      rd_reg(`WDT_OFF_STATUS);
      check(32'(rd_val[0]), 32'h1);
    end
    $display("Test locked period done");
    // Codes 10100 and above all behave the same
    for (int ps = 20; ps < 32; ps++) begin
      do_reset(mk_word(2'h3, 1'b1, 1'b1, 5'(ps)));
      evt_seen = 1'b0;
      repeat (600) begin
        @(posedge mclk);
        #1;
        evt_seen |= timeout_evt;
      end
      rd_reg(`WDT_OFF_COUNT);
      check(32'(evt_seen), 32'h0);
      check(rd_val, ref_cnt);
    end
    $display("Test postscale range done");
    // Software start and stop, then mask and clear the event
    do_reset(mk_word(2'h0, 1'b0, 1'b1, 5'h1));
    check(32'(wdt_running), 32'h0);
    wr_reg(`WDT_OFF_CTRL, 32'h1);
    repeat (2) @(posedge mclk);
    #1;
    check(32'(wdt_running), 32'h1);
    wait_evt(100);
    wait_evt(100);
    check(32'(n), exp_period(5'h1));
    wr_reg(`WDT_OFF_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    #1;
    check(32'(wdt_running), 32'h0);
    check(32'(irq), 32'h0);
    wr_reg(`WDT_OFF_MASK, 32'h1);
    check(32'(irq), 32'h1);
    wr_reg(`WDT_OFF_STATUS, 32'h1);
    check(32'(irq), 32'h0);
    rd_reg(`WDT_OFF_STATUS);
    check(rd_val, 32'h0);
    $display("Test software control done");
    // Window sizes: service just before and just inside the window
    for (int wz = 0; wz < 4; wz++) begin
      do_reset(mk_word(2'(wz), 1'b1, 1'b0, 5'h3));
      svc_at(open_at(wz) * BASE - 2);
      check(32'(evt_seen), 32'h1);
      rd_reg(`WDT_OFF_STATUS);
      check(32'(rd_val[1]), 32'h1);
      svc_at(open_at(wz) * BASE + 1);
      check(32'(evt_seen), 32'h0);
    end
    // Window disabled: early service restarts silently
    do_reset(mk_word(2'h3, 1'b1, 1'b1, 5'h3));
    svc_at(2);
    check(32'(evt_seen), 32'h0);
    rd_reg(`WDT_OFF_STATUS);
    check(32'(rd_val[1]), 32'h0);
    $display("Test window service done");
    stop_test();
  end
endmodule
